/* inc/sscpf_defs.vh */
// Constants shared by the sensor command and power-mode block
// Operation
// - Idle command changes nothing; first reply byte returns status flags
// - Chip reset restores power-up state, normal mode; reset line kept
// - Chip reset accepted any time once chip select gap cleared counter
// - Chip reset from sleep or standby enters normal at once, data-ready low for wake time
// - After chip reset from normal, data-ready low for start-up time, then high
// - Sleep needs request (sets status bit 4) then confirm command
// - Chip reset or normal-run command clears pending request flags
// - Falling edge on wake pin in sleep or standby returns to normal
// - Wake pin debounced about 2 us; driver holds it low long enough
// - Watchdog trigger falling edge in sleep sets critical error and fault bit
// - Entering low power keeps data-ready; wake holds it low for wake time
// - Standby needs request (sets status bit 3) then confirm command
// - Normal-run command wakes from sleep or standby, clears request flags
// - Normal-run while running only clears request and invalid flags, data-ready untouched
// - Measurement start: upper nibble 1101, offset inversion and test bits
// - Selection bits high to low: temp, ambient, DC, LED A/B, chan A/B
// - Diagnostics start is 1011 0000 with same selection and parity byte
// - Measurement begins when chip select returns high
// - Data-ready low a delay after select rises, high when results stored
// - Read-out start is 1100 0011 followed by all-zero byte
// - Register write: 1000 0111, data byte, address, two parity, two zeros
// - Register read: 1000 1110, address upper nibble, then zero byte
// - First byte is a command only when its top bit is one
// - Second reply byte echoes the first control byte
// - Status byte: invalid, power state, requests, test, oscillator, error
// - Selection bits plus parity must be even; mismatch flags invalid
`ifndef SSCPF_DEFS_VH
`define SSCPF_DEFS_VH

`define SSCPF_CMD_IDLE       8'h00
`define SSCPF_CMD_CHIP_RST   8'hF0
`define SSCPF_CMD_SLP_REQ    8'hE1
`define SSCPF_CMD_SLP_CONF   8'hA3
`define SSCPF_CMD_STBY_REQ   8'hE2
`define SSCPF_CMD_STBY_CONF  8'hA6
`define SSCPF_CMD_NORMAL     8'hE4
`define SSCPF_CMD_MEAS_NIB   4'hD
`define SSCPF_CMD_DIAG       8'hB0
`define SSCPF_CMD_READOUT    8'hC3
`define SSCPF_CMD_REG_WR     8'h87
`define SSCPF_CMD_REG_RD     8'h8E
`define SSCPF_TOKEN_BIT      7

`define SSCPF_PWR_NORMAL     2'h2
`define SSCPF_PWR_STBY       2'h1
`define SSCPF_PWR_SLEEP      2'h0

`define SSCPF_ST_INVALID     7
`define SSCPF_ST_SLP_REQ     4
`define SSCPF_ST_STBY_REQ    3

`define SSCPF_CLK_MHZ        250
`define SSCPF_T_STARTUP_US   100
`define SSCPF_T_WAKE_SLP_US  200
`define SSCPF_T_WAKE_STBY_US 50
`define SSCPF_SELECT_TO_READY_DELAY_US     10
`define SSCPF_T_DEBOUNCE_NS  2000
`define SSCPF_CNT_W          20

`endif

/* verilog/sscpf_pin_filter.v */
// Pin synchroniser with debounce filter and falling-edge pulse
`timescale 1ns/1ns
module sscpf_pin_filter #(
  parameter DEB_CYC = 500
) (
  input  wire clk_in,
  input  wire arst_n_in,
  input  wire ce_in,
  input  wire pin_in,
  output reg  fall_out
);
  reg        s1_r;
  reg        s2_r;
  reg        level_r;
  reg [15:0] cnt_r;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r     <= 1'b1;
      s2_r     <= 1'b1;
      level_r  <= 1'b1;
      cnt_r    <= 16'h0000;
      fall_out <= 1'b0;
    end else if (ce_in) begin
      s1_r     <= pin_in;
      s2_r     <= s1_r;
      fall_out <= 1'b0;
      // Level must differ for the whole window, so spikes restart it
      if (s2_r == level_r) begin
        cnt_r <= 16'h0000;
      end else if (cnt_r >= DEB_CYC[15:0] - 16'h0001) begin
        cnt_r    <= 16'h0000;
        level_r  <= s2_r;
        fall_out <= ~s2_r;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule // sscpf_pin_filter

/* verilog/sscpf_spi_slave.v */
// Serial port slave: pin sampling, bit counter, byte shifting
`timescale 1ns/1ns
module sscpf_spi_slave (
  input  wire       clk_in,
  input  wire       arst_n_in,
  input  wire       ce_in,
  input  wire       cs_n_in,
  input  wire       sclk_in,
  input  wire       mosi_in,
  input  wire [7:0] status_in,
  input  wire [7:0] tx_next_in,
  output reg        miso_out,
  output reg        miso_oe_out,
  output reg        byte_done_out,
  output reg  [1:0] byte_idx_out,
  output reg  [7:0] rx_byte_out,
  output reg        frame_end_out,
  output reg  [1:0] nbytes_out
);
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  reg [2:0] bit_r;
  reg [1:0] idx_r;
  reg [7:0] rx_r;
  reg [7:0] tx_r;
  reg       load_r;
  wire      cs_n  = s2_r[0];
  wire      sc_rise = s2_r[1] & ~s3_r[1];
  wire      sc_fall = ~s2_r[1] & s3_r[1];

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r          <= 3'h3;
      s2_r          <= 3'h3;
      s3_r          <= 3'h3;
      bit_r         <= 3'h0;
      idx_r         <= 2'h0;
      rx_r          <= 8'h00;
      tx_r          <= 8'h00;
      load_r        <= 1'b0;
      miso_out      <= 1'b0;
      miso_oe_out   <= 1'b0;
      byte_done_out <= 1'b0;
      byte_idx_out  <= 2'h0;
      rx_byte_out   <= 8'h00;
      frame_end_out <= 1'b0;
      nbytes_out    <= 2'h0;
    end else if (ce_in) begin
      s1_r          <= {mosi_in, sclk_in, cs_n_in};
      s2_r          <= s1_r;
      s3_r          <= s2_r;
      byte_done_out <= 1'b0;
      frame_end_out <= 1'b0;
      miso_oe_out   <= ~cs_n;
      miso_out      <= tx_r[7];
      if (cs_n) begin
        bit_r  <= 3'h0;
        idx_r  <= 2'h0;
        load_r <= 1'b0;
        if (!s3_r[0]) begin
          frame_end_out <= 1'b1;
          nbytes_out    <= idx_r;
        end
      end else if (s3_r[0]) begin
        tx_r <= status_in;
      end else if (sc_rise) begin
        rx_r  <= {rx_r[6:0], s2_r[2]};
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          byte_done_out <= 1'b1;
          byte_idx_out  <= idx_r;
          rx_byte_out   <= {rx_r[6:0], s2_r[2]};
          load_r        <= 1'b1;
          if (idx_r != 2'h3) begin
            idx_r <= idx_r + 2'h1;
          end
        end
      end else if (sc_fall) begin
        // No shift before the first rising edge keeps the MSB on the pin
        if (load_r) begin
          tx_r   <= tx_next_in;
          load_r <= 1'b0;
        end else if (bit_r != 3'h0) begin
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end
endmodule // sscpf_spi_slave

/* verilog/sscpf_top.v */
// Command decoder and power-mode state machine of the sensor interface
`timescale 1ns/1ns
`include "sscpf_defs.vh"
module sscpf_top #(
  parameter [19:0] STARTUP_CYC   = `SSCPF_T_STARTUP_US * `SSCPF_CLK_MHZ,
  parameter [19:0] WAKE_SLP_CYC  = `SSCPF_T_WAKE_SLP_US * `SSCPF_CLK_MHZ,
  parameter [19:0] WAKE_STBY_CYC = `SSCPF_T_WAKE_STBY_US * `SSCPF_CLK_MHZ,
  parameter [19:0] CS_DR_CYC     = `SSCPF_SELECT_TO_READY_DELAY_US * `SSCPF_CLK_MHZ,
  parameter        DEB_CYC       =
    `SSCPF_T_DEBOUNCE_NS * `SSCPF_CLK_MHZ / 1000
) (
  input  wire       SYS_CLK_IN,
  input  wire       ARST_N_IN,
  input  wire       CLK_EN_IN,
  input  wire       SPI_CS_N_IN,
  input  wire       SPI_SCLK_IN,
  input  wire       SPI_MOSI_IN,
  output wire       SPI_MISO_OUT,
  output wire       SPI_MISO_OE_OUT,
  input  wire       WAKE_N_PIN_IN,
  input  wire       WATCHDOG_TRIGGER_PIN_IN,
  input  wire       TEST_MODE_IN,
  input  wire       MEAS_DONE_IN,
  input  wire [7:0] REG_RDATA_IN,
  output reg        DATA_READY_PIN_OUT,
  output reg        RESET_LINE_OUT,
  output reg  [1:0] POWER_STATE_OUT,
  output reg        CRIT_ERR_OUT,
  output reg        FAULT_WT_OUT,
  output reg        CHIP_RESET_OUT,
  output reg        MEAS_START_OUT,
  output reg        DIAG_MODE_OUT,
  output reg  [6:0] MEASURE_SELECT_BITS_OUT,
  output reg  [2:0] OFFSET_INVERT_BITS_OUT,
  output reg        TEST_PULSE_OUT,
  output reg        READOUT_START_OUT,
  output reg        REG_WR_OUT,
  output reg        REG_RD_OUT,
  output reg  [3:0] REG_ADDR_OUT,
  output reg  [7:0] REG_WDATA_OUT
);
  localparam [1:0] DR_READY  = 2'h0;
  localparam [1:0] DR_TIMED  = 2'h1;
  localparam [1:0] DR_SETTLE = 2'h2;
  localparam [1:0] DR_MEAS   = 2'h3;

  wire       byte_done;
  wire [1:0] byte_idx;
  wire [7:0] rx_byte;
  wire       frame_end;
  wire [1:0] nbytes;
  wire       wake_fall;
  wire       wt_fall;

  reg [1:0]  pwr_r;
  reg        slp_req_r;
  reg        stby_req_r;
  reg        invalid_r;
  reg [7:0]  c1_r;
  reg [7:0]  c2_r;
  reg [7:0]  c3_r;
  reg [7:0]  reply_r;
  reg        rd_pend_r;
  reg [1:0]  dr_ph_r;
  reg [19:0] dr_cnt_r;

  wire [7:0] status = {invalid_r, pwr_r, slp_req_r, stby_req_r,
                       TEST_MODE_IN, (pwr_r != `SSCPF_PWR_SLEEP),
                       CRIT_ERR_OUT};
  wire       lowpwr  = (pwr_r != `SSCPF_PWR_NORMAL);
  wire       busy    = (dr_ph_r == DR_SETTLE) || (dr_ph_r == DR_MEAS);
  wire       two_ok  = (nbytes >= 2'h2) && (c2_r == 8'h00);
  wire       sel_par = ~^c2_r;
  wire       wr_par  = (c3_r[3] == ^c2_r) && (c3_r[2] == ^c3_r[7:4]);
  wire [19:0] wake_cyc = (pwr_r == `SSCPF_PWR_SLEEP) ? WAKE_SLP_CYC
                                                      : WAKE_STBY_CYC;

  sscpf_spi_slave u_spi (
    .clk_in        (SYS_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .ce_in         (CLK_EN_IN),
    .cs_n_in       (SPI_CS_N_IN),
    .sclk_in       (SPI_SCLK_IN),
    .mosi_in       (SPI_MOSI_IN),
    .status_in     (status),
    .tx_next_in    (reply_r),
    .miso_out      (SPI_MISO_OUT),
    .miso_oe_out   (SPI_MISO_OE_OUT),
    .byte_done_out (byte_done),
    .byte_idx_out  (byte_idx),
    .rx_byte_out   (rx_byte),
    .frame_end_out (frame_end),
    .nbytes_out    (nbytes)
  );

  sscpf_pin_filter #(
    .DEB_CYC (DEB_CYC)
  ) u_wake (
    .clk_in    (SYS_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .ce_in     (CLK_EN_IN),
    .pin_in    (WAKE_N_PIN_IN),
    .fall_out  (wake_fall)
  );

  // Trigger pin needs only the synchroniser, so the window is one cycle
  sscpf_pin_filter #(
    .DEB_CYC (1)
  ) u_wdt (
    .clk_in    (SYS_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .ce_in     (CLK_EN_IN),
    .pin_in    (WATCHDOG_TRIGGER_PIN_IN),
    .fall_out  (wt_fall)
  );

  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pwr_r                   <= `SSCPF_PWR_NORMAL;
      slp_req_r               <= 1'b0;
      stby_req_r              <= 1'b0;
      invalid_r               <= 1'b0;
      c1_r                    <= 8'h00;
      c2_r                    <= 8'h00;
      c3_r                    <= 8'h00;
      reply_r                 <= 8'h00;
      rd_pend_r               <= 1'b0;
      dr_ph_r                 <= DR_TIMED;
      dr_cnt_r                <= STARTUP_CYC;
      DATA_READY_PIN_OUT      <= 1'b0;
      RESET_LINE_OUT          <= 1'b1;
      POWER_STATE_OUT         <= `SSCPF_PWR_NORMAL;
      CRIT_ERR_OUT            <= 1'b0;
      FAULT_WT_OUT            <= 1'b0;
      CHIP_RESET_OUT          <= 1'b0;
      MEAS_START_OUT          <= 1'b0;
      DIAG_MODE_OUT           <= 1'b0;
      MEASURE_SELECT_BITS_OUT <= 7'h00;
      OFFSET_INVERT_BITS_OUT  <= 3'h0;
      TEST_PULSE_OUT          <= 1'b0;
      READOUT_START_OUT       <= 1'b0;
      REG_WR_OUT              <= 1'b0;
      REG_RD_OUT              <= 1'b0;
      REG_ADDR_OUT            <= 4'h0;
      REG_WDATA_OUT           <= 8'h00;
    end else if (CLK_EN_IN) begin
      CHIP_RESET_OUT    <= 1'b0;
      MEAS_START_OUT    <= 1'b0;
      READOUT_START_OUT <= 1'b0;
      REG_WR_OUT        <= 1'b0;
      REG_RD_OUT        <= 1'b0;
      rd_pend_r         <= REG_RD_OUT;
      POWER_STATE_OUT   <= pwr_r;

      // Data-ready timing
      case (dr_ph_r)
        DR_READY: begin
          DATA_READY_PIN_OUT <= 1'b1;
        end
        DR_TIMED: begin
          DATA_READY_PIN_OUT <= 1'b0;
          if (dr_cnt_r <= 20'h00001) begin
            dr_ph_r <= DR_READY;
          end else begin
            dr_cnt_r <= dr_cnt_r - 20'h00001;
          end
        end
        DR_SETTLE: begin
          if (dr_cnt_r <= 20'h00001) begin
            dr_ph_r            <= DR_MEAS;
            DATA_READY_PIN_OUT <= 1'b0;
          end else begin
            dr_cnt_r <= dr_cnt_r - 20'h00001;
          end
        end
        DR_MEAS: begin
          DATA_READY_PIN_OUT <= 1'b0;
          // Autozero stretch is absorbed by waiting on the done strobe
          if (MEAS_DONE_IN) begin
            dr_ph_r <= DR_READY;
          end
        end
        default: begin
          dr_ph_r <= DR_READY;
        end
      endcase

      // Reply bytes: echo first byte, then register contents for a read
      if (byte_done) begin
        case (byte_idx)
          2'h0: begin
            c1_r    <= rx_byte;
            reply_r <= rx_byte;
          end
          2'h1: begin
            c2_r    <= rx_byte;
            reply_r <= 8'h00;
            if (c1_r == `SSCPF_CMD_REG_RD &&
                pwr_r != `SSCPF_PWR_SLEEP && !busy) begin
              REG_RD_OUT   <= 1'b1;
              REG_ADDR_OUT <= rx_byte[7:4];
            end
          end
          2'h2: begin
            c3_r <= rx_byte;
          end
          default: begin
            c3_r <= c3_r;
          end
        endcase
      end
      if (rd_pend_r) begin
        reply_r <= REG_RDATA_IN;
      end

      // Wake pin acts only in low power, watchdog trigger only in sleep
      if (lowpwr && wake_fall) begin
        pwr_r    <= `SSCPF_PWR_NORMAL;
        dr_ph_r  <= DR_TIMED;
        dr_cnt_r <= wake_cyc;
      end
      if (pwr_r == `SSCPF_PWR_SLEEP && wt_fall) begin
        CRIT_ERR_OUT <= 1'b1;
        FAULT_WT_OUT <= 1'b1;
      end

      // Commands execute when chip select returns high
      if (frame_end && nbytes != 2'h0 && c1_r[`SSCPF_TOKEN_BIT]) begin
        invalid_r <= 1'b1;
        if (c1_r == `SSCPF_CMD_CHIP_RST && two_ok) begin
          invalid_r      <= 1'b0;
          CHIP_RESET_OUT <= 1'b1;
          pwr_r          <= `SSCPF_PWR_NORMAL;
          slp_req_r      <= 1'b0;
          stby_req_r     <= 1'b0;
          dr_ph_r        <= DR_TIMED;
          dr_cnt_r       <= lowpwr ? wake_cyc : STARTUP_CYC;
          // Power-up state clears the error flags unless the trigger
          // fires in the same cycle
          CRIT_ERR_OUT   <= pwr_r == `SSCPF_PWR_SLEEP && wt_fall;
          FAULT_WT_OUT   <= pwr_r == `SSCPF_PWR_SLEEP && wt_fall;
          DIAG_MODE_OUT  <= 1'b0;
        end else if (c1_r == `SSCPF_CMD_NORMAL && two_ok) begin
          invalid_r  <= 1'b0;
          slp_req_r  <= 1'b0;
          stby_req_r <= 1'b0;
          if (lowpwr) begin
            pwr_r    <= `SSCPF_PWR_NORMAL;
            dr_ph_r  <= DR_TIMED;
            dr_cnt_r <= wake_cyc;
          end
        end else if (busy || pwr_r == `SSCPF_PWR_SLEEP) begin
          invalid_r <= 1'b1;
        end else if (c1_r == `SSCPF_CMD_STBY_CONF && two_ok &&
                     stby_req_r && !lowpwr) begin
          invalid_r  <= 1'b0;
          stby_req_r <= 1'b0;
          pwr_r      <= `SSCPF_PWR_STBY;
        end else if (c1_r == `SSCPF_CMD_REG_WR && nbytes == 2'h3 &&
                     c3_r[1:0] == 2'h0 && wr_par) begin
          invalid_r     <= 1'b0;
          REG_WR_OUT    <= 1'b1;
          REG_ADDR_OUT  <= c3_r[7:4];
          REG_WDATA_OUT <= c2_r;
        end else if (c1_r == `SSCPF_CMD_REG_RD && nbytes == 2'h3 &&
                     c2_r[3:0] == 4'h0 && c3_r == 8'h00) begin
          invalid_r <= 1'b0;
        end else if (c1_r == `SSCPF_CMD_READOUT && two_ok) begin
          invalid_r         <= 1'b0;
          READOUT_START_OUT <= 1'b1;
        end else if (lowpwr) begin
          invalid_r <= 1'b1;
        end else if (c1_r == `SSCPF_CMD_SLP_REQ && two_ok) begin
          invalid_r <= 1'b0;
          slp_req_r <= 1'b1;
        end else if (c1_r == `SSCPF_CMD_SLP_CONF && two_ok && slp_req_r) begin
          invalid_r <= 1'b0;
          slp_req_r <= 1'b0;
          pwr_r     <= `SSCPF_PWR_SLEEP;
        end else if (c1_r == `SSCPF_CMD_STBY_REQ && two_ok) begin
          invalid_r  <= 1'b0;
          stby_req_r <= 1'b1;
        end else if (nbytes >= 2'h2 && sel_par &&
                     (c1_r[7:4] == `SSCPF_CMD_MEAS_NIB ||
                      c1_r == `SSCPF_CMD_DIAG)) begin
          invalid_r               <= 1'b0;
          MEAS_START_OUT          <= 1'b1;
          DIAG_MODE_OUT           <= c1_r == `SSCPF_CMD_DIAG;
          MEASURE_SELECT_BITS_OUT <= c2_r[7:1];
          OFFSET_INVERT_BITS_OUT  <= (c1_r == `SSCPF_CMD_DIAG) ? 3'h0
                                                             : c1_r[3:1];
          TEST_PULSE_OUT          <= (c1_r != `SSCPF_CMD_DIAG) & c1_r[0];
          dr_ph_r                 <= DR_SETTLE;
          dr_cnt_r                <= CS_DR_CYC;
        end else begin
          invalid_r <= 1'b1;
        end
      end
    end
  end
endmodule // sscpf_top

/* verif/sscpf_properties.sv */
// Port-level checks of the sensor command and power-mode block
`timescale 1ns/1ns
module sscpf_properties #(
  parameter [19:0] STARTUP_CYC  = 20'h061A8,
  parameter [19:0] WAKE_SLP_CYC = 20'h0C350
) (
  input wire       SYS_CLK_IN,
  input wire       ARST_N_IN,
  input wire       SPI_CS_N_IN,
  input wire       SPI_MISO_OE_OUT,
  input wire       MEAS_DONE_IN,
  input wire       DATA_READY_PIN_OUT,
  input wire       RESET_LINE_OUT,
  input wire [1:0] POWER_STATE_OUT,
  input wire       CRIT_ERR_OUT,
  input wire       FAULT_WT_OUT,
  input wire       CHIP_RESET_OUT,
  input wire       MEAS_START_OUT
);
  logic        busy_r;
  logic [20:0] low_cnt_r;

  // Measurement lows are open-ended, so only other lows are counted
  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      busy_r    <= 1'b0;
      low_cnt_r <= 21'h00000;
    end else begin
      if (MEAS_START_OUT)
        busy_r <= 1'b1;
      else if (CHIP_RESET_OUT || $rose(DATA_READY_PIN_OUT))
        busy_r <= 1'b0;
      if (DATA_READY_PIN_OUT || busy_r)
        low_cnt_r <= 21'h00000;
      else
        low_cnt_r <= low_cnt_r + 21'h00001;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  line_kept_a: assert property (RESET_LINE_OUT)
    else $error("reset line output moved");
  cr_power_a: assert property (
    CHIP_RESET_OUT |-> ##[0:2] POWER_STATE_OUT == 2'h2)
    else $error("chip reset did not restore normal mode");
  cr_dr_low_a: assert property (
    CHIP_RESET_OUT |-> ##[0:2] !DATA_READY_PIN_OUT)
    else $error("data ready not low after chip reset");
  dr_low_bound_a: assert property (
    low_cnt_r <= {1'b0, STARTUP_CYC} + {1'b0, WAKE_SLP_CYC} + 21'h00010)
    else $error("data ready held low too long");
  start_at_cs_a: assert property (
    MEAS_START_OUT |-> SPI_CS_N_IN ##1 !MEAS_START_OUT)
    else $error("measurement start outside chip select high");
  meas_dr_a: assert property (
    MEAS_START_OUT |-> ##[1:12] !DATA_READY_PIN_OUT)
    else $error("data ready not lowered after measurement start");
  done_dr_a: assert property (
    busy_r && MEAS_DONE_IN && !DATA_READY_PIN_OUT
      |-> ##[1:2] DATA_READY_PIN_OUT)
    else $error("data ready not raised when results stored");
  pwr_legal_a: assert property (POWER_STATE_OUT != 2'h3)
    else $error("reserved power state shown");
  crit_in_sleep_a: assert property (
    $rose(CRIT_ERR_OUT) |-> FAULT_WT_OUT && POWER_STATE_OUT == 2'h0)
    else $error("critical error raised outside sleep");
  enter_low_dr_a: assert property (
    $fell(POWER_STATE_OUT[1]) |-> $stable(DATA_READY_PIN_OUT))
    else $error("data ready moved on low-power entry");
  wake_dr_a: assert property (
    $rose(POWER_STATE_OUT[1]) |-> ##2 !DATA_READY_PIN_OUT [*3])
    else $error("data ready not low after wake");
  oe_idle_a: assert property (SPI_CS_N_IN [*6] |-> !SPI_MISO_OE_OUT)
    else $error("data out driven while deselected");

  cr_seen_c: cover property (CHIP_RESET_OUT);
  wake_seen_c: cover property ($rose(POWER_STATE_OUT[1]));
  meas_done_c: cover property (busy_r && $rose(DATA_READY_PIN_OUT));
endmodule // sscpf_properties

/* verif/sscpf_spi_master.sv */
// Host controller model: serial bus master, mode 3
`timescale 1ns/1ns
module sscpf_spi_master (
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input  wire  miso_in,
  input  wire  miso_oe_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Link clock only runs inside a frame; an undriven reply bit reads as X
  task automatic xfer(input logic [23:0] tx, input int nb,
                      output logic [23:0] rx);
    rx = 24'h000000;
    cs_n_out = 1'b0;
    #40;
    for (int i = 0; i < nb * 8; i++) begin
      sclk_out = 1'b0;
      mosi_out = tx[23 - i];
      #40;
      sclk_out = 1'b1;
      rx = {rx[22:0], miso_oe_in ? miso_in : 1'bx};
      #40;
    end
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule // sscpf_spi_master

/* verif/sscpf_test.sv */
// Self-checking bench of the sensor command and power-mode block
`timescale 1ns/1ns
`include "sscpf_defs.vh"
module sscpf_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        wake_n = 1'b1;
  logic        wdt_n = 1'b1;
  logic        test_r = 1'b0;
  logic        done = 1'b0;
  logic [7:0]  rdata = 8'h00;
  logic        dr_mid;
  logic [31:0] seed = 32'h00000027;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_cr = 0, n_ms = 0, n_ro = 0, n_wr = 0, n_rd = 0;
  wire         cs_n, sclk, mosi, miso, oe, dr, crit, flt, crp, msp;
  wire         diag, tp, rop, wrp, rdp;
  wire [1:0]   pwr;
  wire [6:0]   msel;
  wire [2:0]   offs;
  wire [3:0]   addr;
  wire [7:0]   wdat;

  sscpf_top #(.STARTUP_CYC(20'h00014), .WAKE_SLP_CYC(20'h0001E),
    .WAKE_STBY_CYC(20'h0000F), .CS_DR_CYC(20'h00005),
    .DEB_CYC(32'h00000004)) dut (
    .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .CLK_EN_IN(clk_en),
    .SPI_CS_N_IN(cs_n), .SPI_SCLK_IN(sclk), .SPI_MOSI_IN(mosi),
    .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(oe), .WAKE_N_PIN_IN(wake_n),
    .WATCHDOG_TRIGGER_PIN_IN(wdt_n), .TEST_MODE_IN(test_r),
    .MEAS_DONE_IN(done), .REG_RDATA_IN(rdata), .DATA_READY_PIN_OUT(dr),
    .RESET_LINE_OUT(), .POWER_STATE_OUT(pwr), .CRIT_ERR_OUT(crit),
    .FAULT_WT_OUT(flt), .CHIP_RESET_OUT(crp), .MEAS_START_OUT(msp),
    .DIAG_MODE_OUT(diag), .MEASURE_SELECT_BITS_OUT(msel),
    .OFFSET_INVERT_BITS_OUT(offs), .TEST_PULSE_OUT(tp),
    .READOUT_START_OUT(rop), .REG_WR_OUT(wrp), .REG_RD_OUT(rdp),
    .REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdat));

  sscpf_spi_master u_host (.cs_n_out(cs_n), .sclk_out(sclk),
    .mosi_out(mosi), .miso_in(miso), .miso_oe_in(oe));

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    n_cr <= n_cr + crp;
    n_ms <= n_ms + msp;
    n_ro <= n_ro + rop;
    n_wr <= n_wr + wrp;
    n_rd <= n_rd + rdp;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] st(input logic inv, input logic [1:0] p,
                                    input logic sr, tr, ce);
    return {inv, p, sr, tr, test_r, |p, ce};
  endfunction

  task automatic chk(input string nm, input logic [23:0] exp,
                     input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Gap of 1 us lets the bit counter clear before the next frame
  task automatic frm(input logic [23:0] tx, input int nb,
                     output logic [23:0] rx);
    logic [31:0] v;
    v = rnd();
    test_r = v[0];
    u_host.xfer(tx, nb, rx);
    repeat (12) @(posedge clk);
    #1 dr_mid = dr;
    repeat (238) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] c1, c2);
    logic [23:0] rx;
    frm({c1, c2, 8'h00}, 2, rx);
    chk("echo", c1, rx[7:0]);
  endtask

  task automatic idle(input logic inv, input logic [1:0] p,
                      input logic sr, tr, ce);
    logic [23:0] rx;
    frm(24'h000000, 2, rx);
    chk("status", st(inv, p, sr, tr, ce), rx[15:8]);
  endtask

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [23:0] rx;
    logic [7:0]  c, m;
    int          k0;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    clk_en = 1'b0;
    chk("dr_boot", 1'b0, dr);
    repeat (25) @(posedge clk);
    // Start-up count must stay frozen while the enable is low
    #1 chk("dr_frozen", 1'b0, dr);
    clk_en = 1'b1;
    repeat (30) @(posedge clk);
    #1 chk("dr_boot", 1'b1, dr);
    idle(1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd(8'h81, 8'h00);
    idle(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
    r = rnd();
    cmd({1'b0, r[6:0]}, r[15:8]);
    idle(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd(`SSCPF_CMD_NORMAL, 8'h00);
    chk("dr_keep", 1'b1, dr_mid);
    idle(1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd(`SSCPF_CMD_STBY_CONF, 8'h00);
    idle(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd(`SSCPF_CMD_STBY_REQ, 8'h00);
    idle(1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
    cmd(`SSCPF_CMD_NORMAL, 8'h00);
    idle(1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd(`SSCPF_CMD_STBY_REQ, 8'h00);
    cmd(`SSCPF_CMD_STBY_CONF, 8'h00);
    chk("pwr", 2'h1, pwr);
    chk("dr_keep", 1'b1, dr_mid);
    cmd(`SSCPF_CMD_NORMAL, 8'h00);
    chk("pwr", 2'h2, pwr);
    chk("dr_wake", 1'b0, dr_mid);
    cmd(`SSCPF_CMD_SLP_REQ, 8'h00);
    idle(1'b0, 2'h2, 1'b1, 1'b0, 1'b0);
    cmd(`SSCPF_CMD_SLP_CONF, 8'h00);
    chk("pwr", 2'h0, pwr);
    wdt_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("crit", 2'h3, {crit, flt});
    wdt_n = 1'b1;
    wake_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 wake_n = 1'b1;
    repeat (20) @(posedge clk);
    #1 chk("pwr_spike", 2'h0, pwr);
    wake_n = 1'b0;
    for (k0 = 0; k0 < 30 && pwr !== 2'h2; k0++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    #1 chk("pwr_wake", 2'h2, pwr);
    chk("dr_wake", 1'b0, dr);
    wake_n = 1'b1;
    repeat (60) @(posedge clk);
    cmd(`SSCPF_CMD_STBY_REQ, 8'h00);
    cmd(`SSCPF_CMD_STBY_CONF, 8'h00);
    k0 = n_cr;
    cmd(`SSCPF_CMD_CHIP_RST, 8'h00);
    chk("cr_pulse", k0 + 1, n_cr);
    chk("pwr_cr", 2'h2, pwr);
    chk("dr_cr", 1'b0, dr_mid);
    idle(1'b0, 2'h2, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      m = {r[6:0], ^r[6:0] ^ (k == 4)};
      c = (k == 3) ? `SSCPF_CMD_DIAG : {`SSCPF_CMD_MEAS_NIB, r[11:8]};
      k0 = n_ms;
      cmd(c, m);
      chk("start", k0 + (k < 4), n_ms);
      if (k < 4) begin
        chk("sel", r[6:0], msel);
        chk("opts", (k == 3) ? 5'h10 : {1'b0, r[11:8]}, {diag, offs, tp});
        chk("dr_meas", 1'b0, dr_mid);
        @(posedge clk);
        #1 done = 1'b1;
        @(posedge clk);
        #1 done = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("dr_done", 1'b1, dr);
      end
    end
    idle(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
    cmd({`SSCPF_CMD_MEAS_NIB, 4'h0}, 8'h03);
    k0 = n_cr;
    cmd(`SSCPF_CMD_CHIP_RST, 8'h00);
    chk("cr_meas", k0 + 1, n_cr);
    chk("dr_cr", 1'b1, dr);
    k0 = n_ro;
    cmd(`SSCPF_CMD_READOUT, 8'h00);
    chk("ro", k0 + 1, n_ro);
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      rdata = r[31:24];
      k0 = n_wr;
      frm({`SSCPF_CMD_REG_WR, r[7:0], r[11:8], ^r[7:0] ^ (k == 2),
           ^r[11:8], 2'b00}, 3, rx);
      chk("wr", k0 + (k < 2), n_wr);
      if (k < 2)
        chk("wr_regs", r[11:0], {addr, wdat});
      k0 = n_rd;
      frm({`SSCPF_CMD_REG_RD, r[11:8], 4'h0, 8'h00}, 3, rx);
      chk("rd", k0 + 1, n_rd);
      chk("rd_addr", r[11:8], addr);
      chk("rd_data", {`SSCPF_CMD_REG_RD, r[31:24]}, rx[15:0]);
    end
    final_report();
  end

  initial begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule // sscpf_test

bind sscpf_top sscpf_properties #(
  .STARTUP_CYC(STARTUP_CYC),
  .WAKE_SLP_CYC(WAKE_SLP_CYC)
) u_props (.*);
